// ### sim/wdtc_core_assertions.sv
// port assertions for the watchdog control block
`timescale 1ns/1ps
module wdtc_core_assertions
(
	// clock, reset, register port
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic [7:0] reg_rdata_o,
	// supply and actions
	input  wire logic       avdd_ok_i,
	input  wire logic       dvdd_ok_i,
	input  wire logic       supply_monitor_irq_o,
	input  wire logic       wdt_irq_o,
	input  wire logic       wdt_irq_high_prio_o,
	input  wire logic       wdt_sys_reset_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// any timeout action
	wire fire = wdt_irq_o | wdt_sys_reset_o;
	property p_prio; wdt_irq_high_prio_o; endproperty
	a_prio: assert property (p_prio) else $error("low prio");
	property p_sel; fire |-> reg_rdata_o[3] == wdt_irq_o; endproperty
	a_sel: assert property (p_sel) else $error("wrong action");
	property p_stat; fire |-> ##[0:1] reg_rdata_o[2]; endproperty
	a_stat: assert property (p_stat) else $error("no status");
	property p_en; fire |-> $past(reg_rdata_o[1]); endproperty
	a_en: assert property (p_en) else $error("fire unarmed");
	property p_sup;
		supply_monitor_irq_o == !(avdd_ok_i && dvdd_ok_i);
	endproperty
	a_sup: assert property (p_sup) else $error("supply irq");
	property p_supclr; supply_monitor_irq_o [*2] |-> !reg_rdata_o[1];
	endproperty
	a_supclr: assert property (p_supclr) else $error("enable kept");
	property p_lock;
		reg_wr_i && !reg_rdata_o[0] && reg_wdata_i != 8'h01
			|=> $stable(reg_rdata_o[7:3]);
	endproperty
	a_lock: assert property (p_lock) else $error("locked write");
	property p_wr;
		reg_wr_i && reg_rdata_o[0]
			|=> reg_rdata_o[7:3] == $past(reg_wdata_i[7:3]);
	endproperty
	a_wr: assert property (p_wr) else $error("write lost");
endmodule
bind wdtc_core wdtc_core_assertions i_wdtc_core_assertions (
	.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.avdd_ok_i(avdd_ok_i), .dvdd_ok_i(dvdd_ok_i),
	.supply_monitor_irq_o(supply_monitor_irq_o), .wdt_irq_o(wdt_irq_o),
	.wdt_irq_high_prio_o(wdt_irq_high_prio_o),
	.wdt_sys_reset_o(wdt_sys_reset_o));

// ### sim/wdtc_core_tb.sv
// self-checking bench for the watchdog control block
`timescale 1ns/1ps
module wdtc_core_tb;
	localparam int TK = 4;
	logic       sys_clk_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic       avdd_ok_i = 1'b1;
	logic       dvdd_ok_i = 1'b1;
	logic       wr, done, sirq, irq, prio, rst, sel, ir, rs;
	logic [7:0] wdata, rdata, d;
	int         n_mismatch = 0, compares = 0, cyc = 0, n;
	int         seed = 32'he9f2240f;

	always #25 sys_clk_i = ~sys_clk_i;
	wdtc_cpu_model i_wdtc_cpu_model (.sys_clk_i(sys_clk_i),
		.reg_wr_o(wr), .reg_wdata_o(wdata), .instr_done_o(done));
	wdtc_core #(.TICK_CYCLES(TK)) i_wdtc_core (.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i), .reg_wr_i(wr), .reg_wdata_i(wdata),
		.instr_done_i(done), .reg_rdata_o(rdata), .avdd_ok_i(avdd_ok_i),
		.dvdd_ok_i(dvdd_ok_i), .supply_monitor_irq_o(sirq),
		.wdt_irq_o(irq), .wdt_irq_high_prio_o(prio), .wdt_sys_reset_o(rst));

	// expected clocks to timeout for a code
	function automatic int per(input logic [3:0] c);
		return (c == 4'h9) ? 128 * TK : (c == 4'h8) ? 1 : (1 << c) * TK;
	endfunction
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e)
			$display("unexpected %s: expected %h seen %h", s, e, g);
		if (g !== e)
			n_mismatch++;
	endtask
	// clocks until a timeout pulse, at most lim
	task automatic watch(input int lim);
		n = 0;
		{ir, rs} = 2'b00;
		while (n < lim && !(ir | rs))
		begin
			@(posedge sys_clk_i) #1;
			n++;
			{ir, rs} = {irq, rst};
		end
	endtask
	task automatic tmo(input int p);
		watch(p + 4);
		chk("delay", 8'h01, 8'(n + 1 >= p && n <= p + 3));
		chk("action", {7'h00, sel, !sel}, {7'h00, ir, rs});
	endtask
	task automatic print_verdict;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// run ceiling
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc == 8000)
			n_mismatch++;
		if (cyc == 8000)
			print_verdict;
	end

	initial
	begin
		repeat (10) @(posedge sys_clk_i);
		#1 nrst_i = 1'b1;
		chk("ctrl", 8'h00, rdata);
		i_wdtc_cpu_model.wr(8'hf2, 2);
		chk("ctrl", 8'h00, rdata);
		i_wdtc_cpu_model.wr(8'hf2, 1);
		chk("ctrl", 8'h00, rdata);
		// codes 0 to 9, random response except reset for code 8
		for (int c = 0; c < 10; c++)
		begin
			sel = (c == 8) ? 1'b0 : 1'($random(seed));
			d = {c[3:0], sel, 3'b010};
			i_wdtc_cpu_model.wr(d, 0);
			chk("ctrl", d, rdata);
			tmo(per(c[3:0]));
			chk("ctrl", sel ? d | 8'h04 : d ^ 8'h06, rdata);
			if (sel)
				tmo(per(c[3:0]));
			i_wdtc_cpu_model.wr(d & 8'hf8, 0);
			chk("ctrl", d & 8'hf8, rdata);
		end
		// kicks restart the count
		sel = 1'b1;
		repeat (4)
		begin
			i_wdtc_cpu_model.wr(8'h3a, 0);
			watch(16 + ($random(seed) & 7));
			chk("quiet", 8'h00, {ir, rs});
		end
		i_wdtc_cpu_model.wr(8'h3a, 0);
		tmo(32);
		{avdd_ok_i, dvdd_ok_i} = ($random(seed) & 1) ? 2'b01 : 2'b10;
		repeat (2) @(posedge sys_clk_i) #1;
		chk("supply", 8'h01, sirq);
		chk("prio", 8'h01, prio);
		chk("ctrl", 8'h3c, rdata);
		{avdd_ok_i, dvdd_ok_i} = 2'b11;
		i_wdtc_cpu_model.wr(8'ha2, 0);
		watch(300);
		chk("quiet", 8'h00, {ir, rs});
		sel = 1'b0;
		i_wdtc_cpu_model.wr(8'h82, 0);
		tmo(1);
		nrst_i = 1'b0;
		@(posedge sys_clk_i) #1;
		nrst_i = 1'b1;
		chk("ctrl", 8'h00, rdata);
		print_verdict;
	end
endmodule

// ### sim/wdtc_cpu_model.sv
// core-side model driving unlock-and-write sequences
`timescale 1ns/1ps
module wdtc_cpu_model
(
	// clock
	input  wire logic       sys_clk_i,
	// register port
	output logic            reg_wr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            instr_done_o
);
	initial
	begin
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
		instr_done_o = 1'b0;
	end
	// unlock then write, no instruction between
	// mode 0 proper, 1 instruction between, 2 no unlock
	task automatic wr(input logic [7:0] d, input int m);
		// idle edge first, so back-to-back calls never merge
		@(posedge sys_clk_i) #1;
		reg_wr_o = 1'b1;
		reg_wdata_o = (m == 2) ? d : 8'h01;
		@(posedge sys_clk_i) #1;
		if (m == 1)
		begin
			reg_wr_o = 1'b0;
			instr_done_o = 1'b1;
			@(posedge sys_clk_i) #1;
			instr_done_o = 1'b0;
		end
		if (m != 2)
		begin
			reg_wr_o = 1'b1;
			reg_wdata_o = d;
			@(posedge sys_clk_i) #1;
		end
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
	endtask
endmodule

// ### verilog/wdtc_core.sv
// watchdog timer with protected control register
//
// Behaviour
// - With the response select set a timeout raises an interrupt, else a reset.
// - The watchdog interrupt bypasses the global enable at fixed high priority.
// - Unmonitored, the watchdog runs as a periodic timer set by the prescaler.
// - Every timeout sets the status flag in bit 2.
// - The status flag clears by a written 0 or external reset, not by its own.
// - Writing 1 to the enable bit enables and restarts counting from zero.
// - Software rewrites enable within each period or the timeout action fires.
// - Enable clears on written 0, watchdog reset, hardware reset or supply irq.
// - A write counts only when it directly follows setting the unlock bit.
// - The supply irq rises when either supply comparator reads low.
`timescale 1ns/1ps
`include "wdtc_defs.svh"

module wdtc_core
	import wdtc_pkg::*;
#(
	parameter int TICK_CYCLES = `WDTC_TICK_US * `WDTC_CLK_MHZ
)
(
	// clock and external hardware reset
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	// special function register access from the core
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       instr_done_i,
	output logic      [7:0] reg_rdata_o,
	// supply comparators, high means supply above trip point
	input  wire logic       avdd_ok_i,
	input  wire logic       dvdd_ok_i,
	// supply irq and timeout actions
	output logic            supply_monitor_irq_o,
	output logic            wdt_irq_o,
	output logic            wdt_irq_high_prio_o,
	output logic            wdt_sys_reset_o
);

	////////////////////////////////////////////////////////////////////
	// state

	logic [3:0]  timeout_prescale_sel_r;
	logic        interrupt_response_sel_r;
	logic        timeout_status_flag_r;
	logic        watchdog_enable_bit_r;
	logic        write_unlock_bit_r;
	logic [7:0]  ticks_r;
	logic [7:0]  ticks_nxt;
	logic        wd_rst_r;
	logic        irq_r;
	wdtc_state_t state_r;
	wdtc_state_t state_nxt;

	wire         tick;
	wire         wr_ok;
	wire         wr_unlock_only;
	wire         restart;
	wire         supply_low;
	wire [7:0]   limit;
	wire         reserved_pre;
	wire         immediate;
	wire         expire;
	wire         hw_rst;

	////////////////////////////////////////////////////////////////////
	// decode

	assign supply_low = !avdd_ok_i || !dvdd_ok_i;
	assign supply_monitor_irq_o = supply_low;

	// write accepted only right after unlock
	assign wr_ok = reg_wr_i && write_unlock_bit_r;
	// setting unlock alone is allowed only while not armed
	assign wr_unlock_only = reg_wr_i && !write_unlock_bit_r
		&& (reg_wdata_i == 8'h01 << `WDTC_BIT_UNLOCK);

	assign restart = wr_ok && reg_wdata_i[`WDTC_BIT_ENABLE];

	assign reserved_pre = timeout_prescale_sel_r > `WDTC_PRE_LAST;
	assign immediate    = timeout_prescale_sel_r == `WDTC_PRE_IMMEDIATE;
	assign limit        = (timeout_prescale_sel_r < `WDTC_PRE_IMMEDIATE)
		? 8'h01 << timeout_prescale_sel_r[2:0] : 8'h80;

	// timeout when the period elapses unrefreshed
	assign expire = watchdog_enable_bit_r && !reserved_pre
		&& (immediate || (tick && ticks_r + 8'h01 >= limit));

	assign hw_rst = !nrst_i;

	////////////////////////////////////////////////////////////////////
	// base tick

	wdtc_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.run_i     (watchdog_enable_bit_r),
		.restart_i (restart),
		.tick_o    (tick)
	);

	////////////////////////////////////////////////////////////////////
	// period counter and state machine

	assign ticks_nxt = (restart || expire || !watchdog_enable_bit_r)
		? 8'h00 : (tick ? ticks_r + 8'h01 : ticks_r);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			WDTC_IDLE:
				if (watchdog_enable_bit_r)
					state_nxt = WDTC_RUN;
			WDTC_RUN:
				if (expire)
					state_nxt = WDTC_FIRE;
				else if (!watchdog_enable_bit_r)
					state_nxt = WDTC_IDLE;
			WDTC_FIRE:
				state_nxt = watchdog_enable_bit_r ? WDTC_RUN : WDTC_IDLE;
			default:
				state_nxt = WDTC_IDLE;
		endcase
	end

	// counter and state registers
	always_ff @(posedge sys_clk_i)
	begin
		if (hw_rst)
		begin
			ticks_r <= 8'h00;
			state_r <= WDTC_IDLE;
		end
		else
		begin
			ticks_r <= ticks_nxt;
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// unlock arming: one instruction window

	// unlock bit arms the next write and reads back while armed
	always_ff @(posedge sys_clk_i)
	begin
		if (hw_rst)
			write_unlock_bit_r <= 1'b0;
		else if (wr_unlock_only)
			write_unlock_bit_r <= 1'b1;
		else if (instr_done_i || reg_wr_i)
			write_unlock_bit_r <= 1'b0; // any other instruction disarms
	end

	////////////////////////////////////////////////////////////////////
	// control fields

	always_ff @(posedge sys_clk_i)
	begin
		if (hw_rst)
		begin
			timeout_prescale_sel_r   <= 4'h0;
			interrupt_response_sel_r <= 1'b0;
		end
		else if (wr_ok)
		begin
			timeout_prescale_sel_r <=
				reg_wdata_i[`WDTC_PRE_MSB:`WDTC_PRE_LSB];
			interrupt_response_sel_r <= reg_wdata_i[`WDTC_BIT_IRQSEL];
		end
	end

	// enable bit
	always_ff @(posedge sys_clk_i)
	begin
		if (hw_rst)
			watchdog_enable_bit_r <= 1'b0;
		else if (supply_low)
			watchdog_enable_bit_r <= 1'b0;
		else if (expire && !interrupt_response_sel_r)
			watchdog_enable_bit_r <= 1'b0;
		else if (wr_ok)
			watchdog_enable_bit_r <= reg_wdata_i[`WDTC_BIT_ENABLE];
	end

	// status flag
	always_ff @(posedge sys_clk_i)
	begin
		if (hw_rst)
			timeout_status_flag_r <= 1'b0;
		else if (expire)
			// timeout sets status, wins over clear
			timeout_status_flag_r <= 1'b1;
		else if (wr_ok && !reg_wdata_i[`WDTC_BIT_STATUS])
			timeout_status_flag_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// timeout actions

	always_ff @(posedge sys_clk_i)
	begin
		if (hw_rst)
		begin
			wd_rst_r <= 1'b0;
			irq_r    <= 1'b0;
		end
		else
		begin
			wd_rst_r <= expire && !interrupt_response_sel_r;
			irq_r    <= expire && interrupt_response_sel_r;
		end
	end

	// own reset leaves status intact: system reset is an output only
	assign wdt_sys_reset_o = wd_rst_r;
	// interrupt not gated by the global enable
	assign wdt_irq_o           = irq_r;
	assign wdt_irq_high_prio_o = 1'b1;

	// register read-back
	assign reg_rdata_o = {timeout_prescale_sel_r, interrupt_response_sel_r,
		timeout_status_flag_r, watchdog_enable_bit_r, write_unlock_bit_r};

endmodule

// ### verilog/wdtc_defs.svh
// constants for the watchdog timer control block
`ifndef WDTC_DEFS_SVH
`define WDTC_DEFS_SVH

// control register bit positions
`define WDTC_BIT_UNLOCK      0
`define WDTC_BIT_ENABLE      1
`define WDTC_BIT_STATUS      2
`define WDTC_BIT_IRQSEL      3
`define WDTC_PRE_LSB         4
`define WDTC_PRE_MSB         7

// reset value of the control register
`define WDTC_CTRL_RESET      8'h00

// prescaler codes
`define WDTC_PRE_IMMEDIATE   4'h8
`define WDTC_PRE_LAST        4'h9

// base tick: 15.6 ms at the shortest code, counted in microseconds
`define WDTC_TICK_US         15600
`define WDTC_CLK_MHZ         20

`endif

// ### verilog/wdtc_pkg.sv
// types shared by the watchdog timer control block
package wdtc_pkg;

	typedef enum logic [1:0]
	{
		WDTC_IDLE,
		WDTC_RUN,
		WDTC_FIRE
	} wdtc_state_t;

endpackage

// ### verilog/wdtc_tick.sv
// base tick generator: one pulse per base tick while running
`timescale 1ns/1ps
`include "wdtc_defs.svh"

module wdtc_tick #(
	parameter int TICK_CYCLES = `WDTC_TICK_US * `WDTC_CLK_MHZ
)
(
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic nrst_i,
	// control
	input  wire logic run_i,
	input  wire logic restart_i,
	// tick out
	output logic      tick_o
);

	localparam int CW = $clog2(TICK_CYCLES + 1);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	wire           at_end;

	// refuse a tick length the counter cannot serve
	if (TICK_CYCLES < 1)
	begin : g_bad_tick
		$error("wdtc_tick: TICK_CYCLES must be at least 1");
	end

	// terminal count decode
	assign at_end  = (cnt_r == CW'(TICK_CYCLES - 1));
	assign cnt_nxt = (restart_i || !run_i || at_end) ? '0 : cnt_r + 1'b1;

	// base counter
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	// tick pulse, registered
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			tick_o <= 1'b0;
		else
			tick_o <= run_i && !restart_i && at_end;
	end

endmodule
